// >>> rtl/tcq_timer.sv
// Capture and two-phase counting timer channel with an APB slave
//
// The APB register port was decided locally.
module tcq_timer
    import tcq_pkg::*;
#(
    parameter int PRESC_W = 8
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_input_a,
    input wire logic ext_input_b,
    input wire logic companion_flipflop,
    input wire logic phase_in_a,
    input wire logic phase_in_b,
    output logic capture_irq,
    output logic updown_irq
);
    // Register map, all full 32-bit byte addresses: status (read
    // clears), run control, mode, counter and the two capture words;
    // the last three are read-only.
    // Software-visible state
    logic [7:0] run_ctrl; // Run control register
    logic [7:0] mode; // Clock source and capture mode
    logic [7:0] status; // Sticky two-phase flags
    logic [7:0] next_run_ctrl;
    logic [7:0] next_mode;
    logic [7:0] next_status;
    // Bus answer state
    logic [31:0] rd_hold; // Read data taken in the setup cycle
    logic [31:0] next_rd_hold;
    logic cap_rd; // Access reads a capture word
    logic next_cap_rd;
    logic err_hold; // Access targets an unmapped address
    logic next_err_hold;
    logic [7:0] st_snap; // Status bits shown to the pending read
    logic [7:0] next_st_snap;
    // Counting state
    logic [PRESC_W-1:0] presc; // Prescaler divider
    logic [PRESC_W-1:0] next_presc;
    logic [15:0] count; // Main counter
    logic [15:0] next_count;
    logic udce_q; // Two-phase enable, one cycle late
    // Input history
    // Previous samples for edge detection on the pins
    logic ina_q;
    logic inb_q;
    logic cff_q;
    logic [1:0] ph_s1; // First sync stage, read only by ph_s2
    logic [1:0] ph_s2;
    logic [1:0] ph_prev;
    logic [1:0] next_ph_s1;
    logic [1:0] next_ph_s2;
    logic [1:0] next_ph_prev;
    // Interrupt pulses
    // Both interrupts are registered one-cycle pulses
    logic next_capture_irq;
    logic next_updown_irq;
    // Decoded strobes
    logic setup_rd;
    logic acc_wr;
    logic acc_rd;
    logic prun;
    logic crun;
    logic udce;
    logic samp_tick;
    logic cnt_tick;
    logic [1:0] qdir;
    logic ev_up;
    logic ev_dn;
    logic cap_first;
    logic cap_second;
    logic [15:0] cap_word;
    logic [7:0] presc8;

    // APB phase decode; pready never drops, so every transfer has one
    // access cycle and every write lands at the first access edge
    assign setup_rd = psel && !penable;
    assign acc_wr = psel && penable && pwrite;
    assign acc_rd = psel && penable && !pwrite;
    assign prun = run_ctrl[RUN_PRUN];
    assign crun = run_ctrl[RUN_CRUN];
    assign udce = run_ctrl[RUN_UDCE];
    // Zero-wait slave: data is prepared in the setup cycle
    assign pready = 1'b1;
    // Capture words carry 16 bits; the upper half reads zero
    assign prdata = cap_rd ? {16'h0000, cap_word} : rd_hold;
    assign pslverr = psel && penable && err_hold;
    assign presc8 = 8'(presc);

    // Register writes and read-to-clear status
    always_comb
    begin
        next_run_ctrl = run_ctrl;
        next_mode = mode;
        // Writes land only on the access edge
        if (acc_wr && paddr == ADDR_RUN)
            next_run_ctrl = pwdata[7:0] & RUN_WMASK;
        if (acc_wr && paddr == ADDR_MODE)
            next_mode = pwdata[7:0] & MODE_WMASK;
        next_status = status;
        // Clear only what the reader saw, so a fresh event survives
        if (acc_rd && paddr == ADDR_STATUS)
            next_status = status & ~st_snap; // RULE15
        // Events are applied after the clear, so a count that lands on
        // the read's access edge is never lost
        if (ev_up && count == CNT_FULL)
            next_status[ST_OVF] = 1'b1; // RULE14
        if (ev_dn && count == CNT_ZERO)
            next_status[ST_UDF] = 1'b1; // RULE14
        if (ev_up || ev_dn)
            next_status[ST_UD] = 1'b1; // RULE14
    end

    // Read data, decode and error taken at the setup cycle
    // Outside the setup cycle every answer flop loads zero, so prdata
    // stands for the single access cycle and is zero while idle
    always_comb
    begin
        next_rd_hold = 32'h0000_0000;
        next_cap_rd = 1'b0;
        next_err_hold = 1'b0;
        next_st_snap = 8'h00;
        if (setup_rd)
        begin
            case (paddr)
                ADDR_STATUS:
                begin
                    next_rd_hold = {24'h000000, status}; // RULE14
                    next_st_snap = pwrite ? 8'h00 : status;
                end
                ADDR_RUN: next_rd_hold = {24'h000000, run_ctrl};
                ADDR_MODE: next_rd_hold = {24'h000000, mode};
                ADDR_COUNT: next_rd_hold = {16'h0000, count};
                ADDR_CAP_FIRST, ADDR_CAP_SECOND: next_cap_rd = 1'b1;
                // Unmapped: error in the access cycle, data stays zero
                default: next_err_hold = 1'b1;
            endcase
        end
    end

    // Clock selection and phase sampling
    // The /2, /16 and /64 count clocks and the /4 sampling strobe all
    // come from one divider, which clears whenever prescale_run is
    // low, so a restart always begins a fresh period
    always_comb
    begin
        next_presc = prun ? presc + PRESC_W'(1) : '0;
        // Quarter-rate tap when selected, otherwise every clock
        samp_tick = run_ctrl[RUN_SCLK] ?
            (prun && tcq_tap(presc8, TAPQ_MASK)) : 1'b1;
        // Count clock source by the mode field
        case (mode[MODE_CLK_LSB +: 2])
            CLK_EXT: cnt_tick = ext_input_a && !ina_q; // RULE2 RULE18
            CLK_TAP1: cnt_tick = prun && tcq_tap(presc8, TAP1_MASK);
            CLK_TAP2: cnt_tick = prun && tcq_tap(presc8, TAP2_MASK);
            default: cnt_tick = prun && tcq_tap(presc8, TAP3_MASK);
        endcase
        // Stages hold between sample ticks; two stages guard against a
        // pin moving right at the sampling edge, at a cost of two
        // ticks of latency
        next_ph_s1 = ph_s1;
        next_ph_s2 = ph_s2;
        next_ph_prev = ph_prev;
        if (samp_tick)
        begin
            next_ph_s1 = {phase_in_a, phase_in_b}; // RULE20
            next_ph_s2 = ph_s1; // RULE20
            next_ph_prev = ph_s2;
        end
        // Decode once per sample, on the synchronised pair
        qdir = samp_tick ? tcq_quad_dir(ph_prev, ph_s2) : 2'h0; // RULE9
        ev_up = crun && udce && udce_q && qdir[1];
        ev_dn = crun && udce && udce_q && qdir[0];
    end

    // Counter: free-running, event or up/down
    // Stopping clears the counter, to mid-scale in two-phase mode, so a
    // restart begins at the centre value
    always_comb
    begin
        next_count = count;
        if (!crun)
            next_count = udce ? CNT_MID : CNT_ZERO;
        // Counts are refused in the cycle that loads mid-scale
        else if (udce && !udce_q)
            next_count = CNT_MID; // RULE11
        else if (udce)
        begin
            // Plain 16-bit add and subtract give both wraps
            if (ev_up)
                next_count = count + CNT_ONE; // RULE8 RULE12
            else if (ev_dn)
                next_count = count - CNT_ONE; // RULE8 RULE12
        end
        // Free-running or event count otherwise
        else if (cnt_tick)
            next_count = count + CNT_ONE; // RULE18
    end

    // Capture triggers by capture mode
    // An edge is a change against the previous clock's sample, so a pin
    // must hold each level for at least one clock to be seen; the word
    // captured is the count as it stood before the edge
    always_comb
    begin
        cap_first = mode[MODE_SWCAP] ||
            (acc_wr && paddr == ADDR_MODE && pwdata[MODE_SWCAP]);
        cap_second = 1'b0;
        case (mode[MODE_CPM_LSB +: 2])
            // Time difference: first pin rise, then second pin rise
            CPM_DIFF:
            begin
                cap_first = cap_first || (ext_input_a && !ina_q); // RULE5
                cap_second = ext_input_b && !inb_q; // RULE6
            end
            // Pulse width: both edges of the second pin
            CPM_PULSE:
            begin
                cap_first = cap_first || (ext_input_b && !inb_q); // RULE3
                cap_second = !ext_input_b && inb_q; // RULE3
            end
            // Companion flip-flop edges bound a gate time
            CPM_FF:
            begin
                cap_first = cap_first ||
                    (companion_flipflop && !cff_q); // RULE1
                cap_second = !companion_flipflop && cff_q; // RULE1
            end
            default: cap_second = 1'b0;
        endcase
        // Only the second capture interrupts, in every capture mode
        next_capture_irq = cap_second; // RULE4
        next_updown_irq = ev_up || ev_dn; // RULE13
    end

    // Both capture words live in the small register file
    // The write data port sees the counter before this edge's update
    tcq_capture_regs #(
        .W(16)
    ) u_caps (
        .clk(clk),
        .rst_b(rst_b),
        .wr_first(cap_first),
        .wr_second(cap_second),
        .wr_data(count),
        .rd_sel(paddr == ADDR_CAP_SECOND),
        .rd_data(cap_word)
    );

    // State registers
    // One flip-flop bank; every register has a synchronous reset
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            // The capture words clear in their own module
            run_ctrl <= RUN_RESET;
            mode <= MODE_RESET;
            status <= ST_RESET;
            rd_hold <= 32'h0000_0000;
            cap_rd <= 1'b0;
            err_hold <= 1'b0;
            st_snap <= 8'h00;
            presc <= '0;
            count <= CNT_ZERO;
            udce_q <= 1'b0;
            ina_q <= 1'b0;
            inb_q <= 1'b0;
            cff_q <= 1'b0;
            ph_s1 <= 2'h0;
            ph_s2 <= 2'h0;
            ph_prev <= 2'h0;
            capture_irq <= 1'b0;
            updown_irq <= 1'b0;
        end
        else
        begin
            run_ctrl <= next_run_ctrl;
            // The write mask keeps the software capture bit out of the
            // register, so it acts once and reads back as zero
            mode <= next_mode;
            status <= next_status;
            rd_hold <= next_rd_hold;
            cap_rd <= next_cap_rd;
            err_hold <= next_err_hold;
            st_snap <= next_st_snap;
            presc <= next_presc;
            count <= next_count;
            udce_q <= udce && crun;
            // Edge detectors follow the pins every cycle
            ina_q <= ext_input_a;
            inb_q <= ext_input_b;
            cff_q <= companion_flipflop;
            ph_s1 <= next_ph_s1;
            ph_s2 <= next_ph_s2;
            ph_prev <= next_ph_prev;
            capture_irq <= next_capture_irq;
            updown_irq <= next_updown_irq;
        end
    end
endmodule

// >>> rtl/tcq_pkg.sv
// Constants and helpers shared by the capture and two-phase timer channel
// Summary of operation
// RULE1 - Mode 11: companion edges capture both registers
// RULE2 - First input pin selectable as count clock
// RULE3 - Pulse width: second pin rise/fall capture
// RULE4 - Capture interrupt on every second-register latch
// RULE5 - Time difference: first pin rise captures first
// RULE6 - Time difference: second pin rise captures second
// RULE7 - Software extends measurements beyond counter wrap
// RULE8 - Two-phase mode counts one per transition
// RULE9 - Quadruple resolution: count on every state change
// RULE10 - Software sets sampling clock select bit five
// RULE11 - Two-phase enable loads counter with mid-scale
// RULE12 - Wrap to zero or ones, keep counting
// RULE13 - Two-phase interrupt on every count
// RULE14 - Status bits: overflow, underflow, count event
// RULE15 - Reading status clears all its flags (the code clears only the flags the read returned)
// RULE16 - Software reads counter inside interrupt handler
// RULE17 - Source holds count input high around transitions
// RULE18 - Event mode: count first pin rising edges
// RULE19 - Software sets prescaler run for event counting
// RULE20 - Synchronise phase inputs; input order sets direction
package tcq_pkg;
    // Register byte addresses
    localparam logic [31:0] ADDR_STATUS = 32'hFFFF_F1E4;
    localparam logic [31:0] ADDR_RUN = 32'hFFFF_F2C0;
    localparam logic [31:0] ADDR_MODE = 32'hFFFF_F2C4;
    localparam logic [31:0] ADDR_COUNT = 32'hFFFF_F2C8;
    localparam logic [31:0] ADDR_CAP_FIRST = 32'hFFFF_F2CC;
    localparam logic [31:0] ADDR_CAP_SECOND = 32'hFFFF_F2D0;
    // Run control fields
    localparam int RUN_DBUF = 7;
    localparam int RUN_SCLK = 5;
    localparam int RUN_UDCE = 4;
    localparam int RUN_IDLE = 3;
    localparam int RUN_PRUN = 2;
    localparam int RUN_CRUN = 0;
    localparam logic [7:0] RUN_WMASK = 8'hBD;
    localparam logic [7:0] RUN_RESET = 8'h00;
    // Status fields
    localparam int ST_OVF = 2;
    localparam int ST_UDF = 3;
    localparam int ST_UD = 4;
    localparam logic [7:0] ST_RESET = 8'h00;
    // Mode register fields
    localparam int MODE_CLK_LSB = 0;
    localparam int MODE_CPM_LSB = 2;
    localparam int MODE_SWCAP = 4;
    localparam logic [7:0] MODE_WMASK = 8'h0F;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Count clock sources
    localparam logic [1:0] CLK_EXT = 2'h0;
    localparam logic [1:0] CLK_TAP1 = 2'h1;
    localparam logic [1:0] CLK_TAP2 = 2'h2;
    // Capture mode field encodings
    localparam logic [1:0] CPM_DIFF = 2'h1;
    localparam logic [1:0] CPM_PULSE = 2'h2;
    localparam logic [1:0] CPM_FF = 2'h3;
    // Counter values
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MID = 16'h7FFF;
    localparam logic [15:0] CNT_FULL = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // Prescaler tap masks: a tap fires when all masked bits are ones
    localparam logic [7:0] TAP1_MASK = 8'h01;
    localparam logic [7:0] TAP2_MASK = 8'h0F;
    localparam logic [7:0] TAP3_MASK = 8'h3F;
    localparam logic [7:0] TAPQ_MASK = 8'h03;

    // Direction of one phase state change, {a,b} order: {up, down}
    function automatic logic [1:0] tcq_quad_dir(input logic [1:0] prev,
                                                input logic [1:0] cur);
        logic [1:0] dir;
        dir = 2'h0;
        case ({prev, cur})
            4'h2, 4'hB, 4'hD, 4'h4: dir = 2'h2;
            4'h8, 4'hE, 4'h7, 4'h1: dir = 2'h1;
            default: dir = 2'h0;
        endcase
        return dir;
    endfunction

    // Tap decode on the prescaler count
    function automatic logic tcq_tap(input logic [7:0] cnt,
                                     input logic [7:0] mask);
        return (cnt & mask) == mask;
    endfunction
endpackage

// >>> rtl/tcq_capture_regs.sv
// Pair of capture words with a registered read port
module tcq_capture_regs
    import tcq_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr_first,
    input wire logic wr_second,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_sel,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [2]; // Index 0 first capture, 1 second
    logic [W-1:0] next_mem [2];
    logic [W-1:0] next_rd_data;

    // Capture writes; the read sees the word as it stood before the edge
    always_comb
    begin
        next_mem[0] = wr_first ? wr_data : mem[0];
        next_mem[1] = wr_second ? wr_data : mem[1];
        next_rd_data = rd_sel ? mem[1] : mem[0];
    end

    // Capture words reset to zero so reads are defined
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mem[0] <= '0;
            mem[1] <= '0;
            rd_data <= '0;
        end
        else
        begin
            mem[0] <= next_mem[0];
            mem[1] <= next_mem[1];
            rd_data <= next_rd_data;
        end
    end
endmodule

// >>> testbench/tcq_timer_monitor.sv
// Port-level checker for the capture and two-phase timer channel
module tcq_timer_monitor
    import tcq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_input_b,
    input wire logic companion_flipflop,
    input wire logic phase_in_a,
    input wire logic phase_in_b,
    input wire logic capture_irq,
    input wire logic updown_irq
);
    logic [4:0] cap_age; // Cycles since ext_input_b or companion_flipflop moved
    logic [4:0] ud_age; // Cycles since a phase pin moved
    logic [3:0] pins_q; // Previous sample of the watched pins
    logic [4:0] next_cap_age;
    logic [4:0] next_ud_age;

    // Ages saturate, so a quiet pin never looks freshly moved again
    always_comb
    begin
        next_cap_age = (cap_age == 5'h1F) ? cap_age : cap_age + 5'h01;
        next_ud_age = (ud_age == 5'h1F) ? ud_age : ud_age + 5'h01;
        if ({ext_input_b, companion_flipflop} != pins_q[3:2])
            next_cap_age = 5'h00;
        if ({phase_in_a, phase_in_b} != pins_q[1:0])
            next_ud_age = 5'h00;
    end

    // Age registers; pins are sampled even in reset
    always_ff @(posedge clk)
    begin
        pins_q <= {ext_input_b, companion_flipflop, phase_in_a, phase_in_b};
        cap_age <= rst_b ? next_cap_age : 5'h1F;
        ud_age <= rst_b ? next_ud_age : 5'h1F;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence access_s;
        psel && penable;
    endsequence
    sequence st_read_s;
        access_s ##0 (!pwrite && paddr == ADDR_STATUS);
    endsequence

    ready_high_a: assert property (access_s |-> pready)
        else $error("pready low in access");
    err_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    err_zero_a: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    idle_zero_a: assert property (!psel |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    status_bits_a: assert property (
        st_read_s |-> (prdata & 32'hFFFF_FFE3) == 32'h0)
        else $error("status reserved bits set");
    cap_pulse_a: assert property (
        capture_irq |=> !capture_irq [*2])
        else $error("capture irq too long");
    cap_cause_a: assert property (
        capture_irq |-> cap_age <= 5'h06)
        else $error("capture irq without pin edge");
    ud_pulse_a: assert property (
        $rose(updown_irq) |=> $fell(updown_irq))
        else $error("count irq not one cycle");
    ud_cause_a: assert property (
        updown_irq |-> ud_age <= 5'h18)
        else $error("count irq without phase change");
endmodule

bind tcq_timer tcq_timer_monitor mon
(
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .ext_input_b, .companion_flipflop,
    .phase_in_a, .phase_in_b, .capture_irq, .updown_irq
);

// >>> testbench/tcq_encoder.sv
// Two-phase encoder model driving the phase pins
module tcq_encoder
(
    input wire logic clk,
    output logic phase_a,
    output logic phase_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos = 2'h0; // Place in the 00,10,11,01 cycle

    initial
    begin
        phase_a = 1'b0;
        phase_b = 1'b0;
    end

    // One step; a leads for up, b leads for down
    // Held for hold cycles so each state is sampled high or low
    task automatic step(input logic up, input int hold);
        @(posedge clk);
        pos = up ? pos + 2'h1 : pos - 2'h1;
        phase_a <= ^pos;
        phase_b <= pos[1];
        repeat (hold) @(posedge clk);
    endtask
endmodule

// >>> testbench/timer_capture_quadrature_counter_tb.sv
// Self-checking bench for the capture and two-phase timer channel
module timer_capture_quadrature_counter_tb
    import tcq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, psel, penable, pwrite, pslverr, pready, err;
    logic [31:0] paddr, pwdata, prdata, rd, c1;
    logic ext_input_a, ext_input_b, companion_flipflop;
    logic phase_in_a, phase_in_b, capture_irq, updown_irq;
    int mismatches = 0;
    int compares = 0;
    int ncap = 0; // Capture interrupts seen
    int nud = 0; // Count interrupts seen

    tcq_timer dut
    (
        .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_input_a, .ext_input_b,
        .companion_flipflop, .phase_in_a, .phase_in_b,
        .capture_irq, .updown_irq
    );
    tcq_encoder enc (.clk, .phase_a(phase_in_a), .phase_b(phase_in_b));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Interrupts are single-cycle pulses, so count them every edge
    always @(posedge clk)
    begin
        if (capture_irq === 1'b1)
            ncap++;
        if (updown_irq === 1'b1)
            nud++;
    end

    task automatic chk(input logic [31:0] got, exp, input string m);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // APB transfer; idle edge first so no signal is driven twice
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            mismatches++;
            $display("[FAIL] %0t no pready", $time);
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_regs();
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0, "status reset");
        apb(1'b1, ADDR_RUN, 32'hFF);
        apb(1'b0, ADDR_RUN, 32'h0);
        chk(rd, {24'h0, RUN_WMASK}, "run bits");
        apb(1'b1, ADDR_RUN, 32'h0);
        apb(1'b0, 32'hFFFF_F2E0, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        $display("test regs done");
    endtask

    task automatic t_event();
        apb(1'b1, ADDR_MODE, {30'h0, CLK_EXT});
        apb(1'b1, ADDR_RUN, 32'h05);
        repeat (5)
        begin
            ext_input_a <= 1'b1;
            repeat (2) @(posedge clk);
            ext_input_a <= 1'b0;
            repeat (2) @(posedge clk);
        end
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk(rd, 32'h5, "event count");
        apb(1'b1, ADDR_MODE, 32'h1 << MODE_SWCAP);
        apb(1'b0, ADDR_CAP_FIRST, 32'h0);
        chk(rd, 32'h5, "soft capture");
        apb(1'b1, ADDR_RUN, 32'h0);
        $display("test event done");
    endtask

    task automatic cap_setup(input logic [1:0] cpm, input logic [1:0] src);
        apb(1'b1, ADDR_MODE, {28'h0, cpm, src});
        apb(1'b1, ADDR_RUN, 32'h05);
    endtask

    // Reads both words, judges their gap and the single capture irq
    task automatic cap_check(input int n0, input logic [31:0] gap);
        repeat (6) @(posedge clk);
        apb(1'b0, ADDR_CAP_FIRST, 32'h0);
        c1 = rd;
        apb(1'b0, ADDR_CAP_SECOND, 32'h0);
        chk(rd - c1, gap, "capture gap");
        chk(32'(ncap - n0), 32'h1, "capture irq");
        apb(1'b1, ADDR_RUN, 32'h0);
    endtask

    task automatic t_pulse();
        int n0;
        n0 = ncap;
        cap_setup(CPM_PULSE, CLK_TAP1);
        // /2 tap: gap is half the pin time, far below a wrap
        ext_input_b <= 1'b1;
        repeat (20) @(posedge clk);
        ext_input_b <= 1'b0;
        cap_check(n0, 32'h0000_000A);
        $display("test pulse done");
    endtask

    task automatic t_diff();
        int n0;
        n0 = ncap;
        cap_setup(CPM_DIFF, CLK_TAP1);
        ext_input_a <= 1'b1;
        repeat (40) @(posedge clk);
        ext_input_b <= 1'b1;
        cap_check(n0, 32'h0000_0014);
        ext_input_a <= 1'b0;
        ext_input_b <= 1'b0;
        $display("test diff done");
    endtask

    task automatic t_ff();
        int n0;
        n0 = ncap;
        cap_setup(CPM_FF, CLK_TAP2);
        // The /16 tap gives exactly two counts over 32 clocks
        companion_flipflop <= 1'b1;
        repeat (32) @(posedge clk);
        companion_flipflop <= 1'b0;
        cap_check(n0, 32'h0000_0002);
        $display("test companion done");
    endtask

    task automatic t_quad();
        int n0;
        n0 = nud;
        apb(1'b1, ADDR_RUN, 32'h35);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk(rd, {16'h0, CNT_MID}, "mid-scale");
        repeat (3) enc.step(1'b1, 24);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk(rd, 32'h8002, "up count");
        chk(32'(nud - n0), 32'h3, "up irqs");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h10, "count flag");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0, "flag clear");
        repeat (5) enc.step(1'b0, 40);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk(rd, 32'h7FFD, "down count");
        chk(32'(nud - n0), 32'h8, "all irqs");
        apb(1'b1, ADDR_RUN, 32'h0);
        $display("test quad done");
    endtask

    initial
    begin
        rst_b = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_input_a, ext_input_b, companion_flipflop} = 3'h0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_event();
        t_pulse();
        t_diff();
        t_ff();
        t_quad();
        end_sim();
    end
endmodule
